// ### hdl/lbtr_ctrl.sv
// Busy and timer recovery control for one multiple-frame link entity.
// Assumes decoded, validated received frames arrive as one-cycle pulses
// with their N(R), and the transmit side takes one send request per cycle.
`timescale 1ns/100ps
module lbtr_ctrl
  import lbtr_pkg::*;
#(
  parameter int unsigned T200_CYCLES = T200_CYC,
  parameter int unsigned N200        = N200_DEF,
  parameter int unsigned K_WIN       = K_DEF
) (
  input  wire logic            clk_i,
  input  wire logic            resetn_i,
  input  wire logic            rx_valid_i,
  input  wire logic            rx_is_i_i,
  input  wire logic            rx_is_sup_i,
  input  wire logic      [1:0] rx_sup_type_i,
  input  wire logic            rx_cmd_i,
  input  wire logic            rx_pf_i,
  input  wire lbtr_seq_t       rx_nr_i,
  input  wire logic            rx_sabme_i,
  input  wire logic            rx_frmr_i,
  input  wire logic            rx_dm_i,
  input  wire logic            rx_ua_i,
  input  wire logic            mode_setting_i,
  input  wire logic            est_req_i,
  input  wire logic            frame_reject_i,
  input  wire logic            reest_opt_i,
  input  wire logic            own_busy_i,
  input  wire logic            seq_err_i,
  input  wire logic            rej_sent_i,
  input  wire lbtr_seq_t       vr_i,
  input  wire logic            i_sent_i,
  input  wire logic            i_pending_i,
  output logic                 sup_req_o,
  output logic           [1:0] sup_type_o,
  output logic                 sup_cmd_o,
  output logic                 sup_pf_o,
  output lbtr_seq_t            sup_nr_o,
  output logic                 i_allow_o,
  output logic                 i_discard_o,
  output lbtr_seq_t            vs_o,
  output lbtr_seq_t            va_o,
  output logic                 peer_busy_o,
  output logic                 recovery_o,
  output logic     [CNT_W-1:0] retry_cnt_o,
  output logic                 reest_o,
  output logic                 mdl_error_o
);
  lbtr_state_e      st_r, st_nxt;
  lbtr_seq_t        vs_r, vs_nxt, va_r, va_nxt;
  logic             pbusy_r, pbusy_nxt;
  logic             fexp_r, fexp_nxt;
  logic [CNT_W-1:0] rc_r, rc_nxt;
  logic             obusy_r;
  logic             sreq_r, sreq_nxt, scmd_r, scmd_nxt, spf_r, spf_nxt;
  logic [1:0]       styp_r, styp_nxt;
  logic             disc_r, disc_nxt, re_r, re_nxt, err_r, err_nxt;
  logic             t_start, t_stop, t_run, t_exp;
  logic [1:0]       sel_type;
  logic             s_rr, s_rnr, s_rej, s_fresp, s_poll, nr_ok;
  lbtr_seq_t        nr_off, vs_off, out_cnt;

  lbtr_timer #(.CYCLES(T200_CYCLES)) u_t200 (
    .clk_i     (clk_i),
    .resetn_i  (resetn_i),
    .start_i   (t_start),
    .stop_i    (t_stop),
    .running_o (t_run),
    .expire_o  (t_exp)
  );

  lbtr_sup_sel u_sel (
    .own_busy_i (own_busy_i),
    .seq_err_i  (seq_err_i),
    .rej_sent_i (rej_sent_i),
    .sup_type_o (sel_type)
  );

  always_comb begin
    s_rr    = rx_valid_i && rx_is_sup_i && (rx_sup_type_i == ST_RR);
    s_rnr   = rx_valid_i && rx_is_sup_i && (rx_sup_type_i == ST_RNR);
    s_rej   = rx_valid_i && rx_is_sup_i && (rx_sup_type_i == ST_REJ);
    s_fresp = rx_valid_i && rx_is_sup_i && !rx_cmd_i && rx_pf_i;
    s_poll  = rx_valid_i && rx_cmd_i && rx_pf_i && (rx_is_sup_i || rx_is_i_i);
    // Wrapping subtraction keeps the window test modulo 128
    nr_off  = rx_nr_i - va_r;
    vs_off  = vs_r - va_r;
    out_cnt = vs_r - va_r;
    nr_ok   = (nr_off <= vs_off);
  end

  always_comb begin
    st_nxt    = st_r;
    vs_nxt    = vs_r;
    va_nxt    = va_r;
    pbusy_nxt = pbusy_r;
    fexp_nxt  = fexp_r;
    rc_nxt    = rc_r;
    sreq_nxt  = 1'b0;
    styp_nxt  = sel_type;
    scmd_nxt  = 1'b0;
    spf_nxt   = 1'b0;
    disc_nxt  = 1'b0;
    re_nxt    = 1'b0;
    err_nxt   = 1'b0;
    t_start   = 1'b0;
    t_stop    = 1'b0;
    if (st_r == LBTR_IDLE && !est_req_i && !rx_sabme_i) begin
      st_nxt = LBTR_IDLE;
    end
    if (i_sent_i) begin
      vs_nxt = vs_r + 7'h1;
      if (!t_run) begin
        t_start = 1'b1;
      end
    end
    if (rx_valid_i && (rx_is_sup_i || rx_is_i_i) && nr_ok) begin
      va_nxt = rx_nr_i;
    end
    // Every I frame is dropped while busy, whether or not its N(R) was usable
    if (rx_valid_i && rx_is_i_i && own_busy_i) begin
      disc_nxt = 1'b1;
    end
    if (s_rnr && !mode_setting_i) begin
      pbusy_nxt = 1'b1;
      if (!(s_fresp && fexp_r)) begin
        if (!fexp_r) begin
          t_start = 1'b1;
        end
      end
    end
    if ((s_rr || s_rej) && !(rx_cmd_i == 1'b0 && rx_pf_i && fexp_r)) begin
      // Busy clears; while a final is expected, sending waits for it
      pbusy_nxt = 1'b0;
    end
    if (s_fresp && fexp_r) begin
      st_nxt   = LBTR_EST;
      fexp_nxt = 1'b0;
      if (nr_ok) begin
        vs_nxt = rx_nr_i;
      end
      if (s_rnr) begin
        t_start = 1'b1;
      end else begin
        pbusy_nxt = 1'b0;
        t_stop    = 1'b1;
      end
    end
    // Polled commands leave V(S) alone: only the branch above loads it
    if (s_poll) begin
      sreq_nxt = 1'b1;
      spf_nxt  = 1'b1;
      styp_nxt = own_busy_i ? ST_RNR : ST_RR;
      if (!own_busy_i && rx_is_sup_i) begin
        styp_nxt = sel_type;
      end
    end else if (own_busy_i != obusy_r) begin
      // Entering busy sends RNR, leaving sends RR or REJ with V(R)
      sreq_nxt = 1'b1;
      styp_nxt = sel_type;
    end
    if (t_exp) begin
      if (st_r != LBTR_RECOV) begin
        st_nxt = LBTR_RECOV;
        rc_nxt = '0;
      end else begin
        rc_nxt = rc_r + 1'b1;
      end
      if ((st_r != LBTR_RECOV) || (rc_r + 1'b1 < CNT_W'(N200))) begin
        t_start  = 1'b1;
        sreq_nxt = 1'b1;
        scmd_nxt = 1'b1;
        spf_nxt  = 1'b1;
        styp_nxt = sel_type;
        fexp_nxt = 1'b1;
      end else begin
        re_nxt   = 1'b1;
        err_nxt  = 1'b1;
        st_nxt   = LBTR_EST;
        fexp_nxt = 1'b0;
      end
    end
    if (rx_sabme_i) begin
      pbusy_nxt = 1'b0;
    end
    if ((rx_sabme_i && st_r != LBTR_IDLE) || est_req_i || frame_reject_i
        || (rx_frmr_i && st_r != LBTR_IDLE)
        || (rx_dm_i && !rx_pf_i && st_r != LBTR_IDLE)
        || (rx_dm_i && rx_pf_i && st_r == LBTR_RECOV)
        || (reest_opt_i && (rx_ua_i || (rx_dm_i && rx_pf_i)) && st_r == LBTR_EST)) begin
      re_nxt = 1'b1;
      if (!est_req_i && !rx_sabme_i) begin
        err_nxt = 1'b1;
      end
    end
    if (re_nxt) begin
      st_nxt   = LBTR_EST;
      fexp_nxt = 1'b0;
      rc_nxt   = '0;
      t_stop   = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_r    <= LBTR_IDLE;
      vs_r    <= '0;
      va_r    <= '0;
      pbusy_r <= 1'b0;
      fexp_r  <= 1'b0;
      rc_r    <= '0;
      obusy_r <= 1'b0;
      sreq_r  <= 1'b0;
      styp_r  <= ST_RR;
      scmd_r  <= 1'b0;
      spf_r   <= 1'b0;
      disc_r  <= 1'b0;
      re_r    <= 1'b0;
      err_r   <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      vs_r    <= vs_nxt;
      va_r    <= va_nxt;
      pbusy_r <= pbusy_nxt;
      fexp_r  <= fexp_nxt;
      rc_r    <= rc_nxt;
      obusy_r <= own_busy_i;
      sreq_r  <= sreq_nxt;
      styp_r  <= styp_nxt;
      scmd_r  <= scmd_nxt;
      spf_r   <= spf_nxt;
      disc_r  <= disc_nxt;
      re_r    <= re_nxt;
      err_r   <= err_nxt;
    end
  end

  // Window check guards new frames only; retransmission is the sender's call
  assign i_allow_o   = i_pending_i && !pbusy_r && !fexp_r
                       && (out_cnt < SEQ_W'(K_WIN));
  assign sup_req_o   = sreq_r;
  assign sup_type_o  = styp_r;
  assign sup_cmd_o   = scmd_r;
  assign sup_pf_o    = spf_r;
  assign sup_nr_o    = vr_i;
  assign i_discard_o = disc_r;
  assign vs_o        = vs_r;
  assign va_o        = va_r;
  assign peer_busy_o = pbusy_r;
  assign recovery_o  = (st_r == LBTR_RECOV);
  assign retry_cnt_o = rc_r;
  assign reest_o     = re_r;
  assign mdl_error_o = err_r;
endmodule : lbtr_ctrl

// ### hdl/lbtr_pkg.sv
// Constants and types shared by the busy and timer recovery control block.
// Assumes one 10 MHz clock; all sequence numbers are 7 bits wide.
// Functional notes
// - Valid RNR outside mode setting sets peer busy
// - RNR poll answered RR, REJ or RNR final
// - RNR final response clears recovery, loads V(S)
// - No information frames while peer busy
// - Polled RR/RNR commands never change V(S)
// - RNR N(R) acknowledges frames; V(A) takes it
// - Restart T200 after RNR unless final expected
// - T200 expiry enters recovery or counts retries
// - Below N200: restart T200, send polled enquiry
// - At N200: re-establish and report error
// - Poll answered promptly with final, busy shown
// - Final response resets T200; RR/REJ clear busy
// - Enquiry RR/REJ clears busy, sending still waits
// - Enquiry RNR keeps busy, poll gets final
// - SABME clears peer busy
// - Supervisory type: RNR, REJ, else RR
// - Entering own busy sends RNR promptly
// - Busy: information frames dropped after V(A) update
// - Busy: supervisory frames processed, poll gets RNR
// - Leaving busy sends RR or REJ
// - Final response ends recovery, loads valid N(R)
// - Re-establishment on listed events
// - Stop new frames at V(A) plus k
package lbtr_pkg;
  localparam int unsigned SEQ_W       = 7;
  localparam int unsigned T200_MS     = 1000;
  localparam int unsigned CLK_KHZ     = 10000;
  localparam int unsigned T200_CYC    = T200_MS * CLK_KHZ;
  localparam int unsigned N200_DEF    = 3;
  localparam int unsigned K_DEF       = 7;
  localparam int unsigned CNT_W       = 4;
  localparam logic [1:0]  ST_RR       = 2'h0;
  localparam logic [1:0]  ST_RNR      = 2'h1;
  localparam logic [1:0]  ST_REJ      = 2'h2;
  typedef logic [SEQ_W-1:0] lbtr_seq_t;
  typedef enum logic [1:0] {
    LBTR_IDLE  = 2'h0,
    LBTR_EST   = 2'h1,
    LBTR_RECOV = 2'h3
  } lbtr_state_e;
endpackage : lbtr_pkg

// ### hdl/lbtr_sup_sel.sv
// Chooses the supervisory frame type from own receiver state.
// Pure combinational; inputs come unregistered straight from the caller's ports.
`timescale 1ns/100ps
module lbtr_sup_sel
  import lbtr_pkg::*;
(
  input  wire logic       own_busy_i,
  input  wire logic       seq_err_i,
  input  wire logic       rej_sent_i,
  output logic      [1:0] sup_type_o
);
  always_comb begin
    if (own_busy_i) begin
      sup_type_o = ST_RNR;
    end else if (seq_err_i && !rej_sent_i) begin
      sup_type_o = ST_REJ;
    end else begin
      sup_type_o = ST_RR;
    end
  end
endmodule : lbtr_sup_sel

// ### hdl/lbtr_timer.sv
// T200 down counter with start, stop and expiry pulse.
// Assumes start and stop come from logic on the same clock.
`timescale 1ns/100ps
module lbtr_timer
  import lbtr_pkg::*;
#(
  parameter int unsigned CYCLES = T200_CYC
) (
  input  wire logic clk_i,
  input  wire logic resetn_i,
  input  wire logic start_i,
  input  wire logic stop_i,
  output logic      running_o,
  output logic      expire_o
);
  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic        run_r;
  logic        run_nxt;
  logic        exp_r;
  logic        exp_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    run_nxt = run_r;
    exp_nxt = 1'b0;
    if (start_i) begin
      // Restart wins over stop so a reset-and-restart is one pulse
      cnt_nxt = 32'(CYCLES - 1);
      run_nxt = 1'b1;
    end else if (stop_i) begin
      run_nxt = 1'b0;
    end else if (run_r) begin
      if (cnt_r == 32'h0) begin
        run_nxt = 1'b0;
        exp_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r - 32'h1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_r <= 32'h0;
      run_r <= 1'b0;
      exp_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      run_r <= run_nxt;
      exp_r <= exp_nxt;
    end
  end

  assign running_o = run_r;
  assign expire_o  = exp_r;
endmodule : lbtr_timer

// ### verification/lbtr_ctrl_properties.sv
// Assertions on the busy and timer recovery control block.
// Bound into lbtr_ctrl; sees only its ports.
`timescale 1ns/100ps
module lbtr_ctrl_props
  import lbtr_pkg::*;
(
  input wire logic             clk_i,
  input wire logic             resetn_i,
  input wire logic             rx_valid_i,
  input wire logic             rx_is_i_i,
  input wire logic             rx_is_sup_i,
  input wire logic       [1:0] rx_sup_type_i,
  input wire logic             rx_cmd_i,
  input wire logic             rx_pf_i,
  input wire logic             rx_sabme_i,
  input wire logic             mode_setting_i,
  input wire logic             own_busy_i,
  input wire logic             i_sent_i,
  input wire logic             sup_req_o,
  input wire logic       [1:0] sup_type_o,
  input wire logic             sup_cmd_o,
  input wire logic             sup_pf_o,
  input wire logic             i_allow_o,
  input wire logic             i_discard_o,
  input wire lbtr_seq_t        vs_o,
  input wire logic             peer_busy_o,
  input wire logic             recovery_o,
  input wire logic [CNT_W-1:0] retry_cnt_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_poll_in; rx_valid_i && rx_is_sup_i && rx_cmd_i && rx_pf_i; endsequence
  sequence s_poll_out; sup_req_o && sup_cmd_o && sup_pf_o; endsequence
  a_rnr_sets_busy: assert property (
    rx_valid_i && rx_is_sup_i && rx_sup_type_i == ST_RNR && !mode_setting_i && !rx_sabme_i
    |=> peer_busy_o) else $error("busy not set");
  a_poll_gets_final: assert property (
    s_poll_in |=> sup_req_o && sup_pf_o && !sup_cmd_o) else $error("no final reply");
  a_busy_blocks_i: assert property (
    peer_busy_o |-> !i_allow_o) else $error("sending while peer busy");
  a_poll_keeps_vs: assert property (
    s_poll_in ##0 (rx_sup_type_i != ST_REJ && !i_sent_i) |=> $stable(vs_o)) else $error("vs moved");
  a_own_busy_poll: assert property (
    own_busy_i && rx_valid_i && rx_cmd_i && rx_pf_i |=> sup_req_o && sup_type_o == ST_RNR)
    else $error("no busy final");
  a_busy_discard: assert property (
    own_busy_i && rx_valid_i && rx_is_i_i |=> i_discard_o) else $error("no discard");
  a_sabme_clears: assert property (
    rx_sabme_i |=> !peer_busy_o) else $error("busy kept");
  a_enter_recov: assert property (
    $rose(recovery_o) |-> s_poll_out ##0 retry_cnt_o == 0) else $error("bad recovery entry");
endmodule : lbtr_ctrl_props

bind lbtr_ctrl lbtr_ctrl_props u_props (.*);

// ### verification/lbtr_peer.sv
// Peer link entity model: delivers decoded frames and answers polls.
// Assumes one caller of send at a time, on the block's clock.
`timescale 1ns/100ps
module lbtr_peer
  import lbtr_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic sup_req_i,
  input  wire logic sup_cmd_i,
  input  wire logic sup_pf_i,
  output logic       rx_valid_o,
  output logic       rx_is_i_o,
  output logic       rx_is_sup_o,
  output logic [1:0] rx_type_o,
  output logic       rx_cmd_o,
  output logic       rx_pf_o,
  output lbtr_seq_t  rx_nr_o,
  output logic       rx_sabme_o
);
  int         ans_dly  = 0; // Zero keeps the peer silent so T200 runs out
  logic [1:0] ans_type = ST_RR;
  lbtr_seq_t  ans_nr   = '0;
  initial {rx_valid_o, rx_is_i_o, rx_is_sup_o, rx_type_o, rx_cmd_o, rx_pf_o, rx_nr_o, rx_sabme_o} = '0;
  task automatic send(input logic i, input logic [1:0] t, input logic c, p, input lbtr_seq_t n,
                      input logic u);
    @(posedge clk_i);
    #1;
    {rx_valid_o, rx_is_i_o, rx_is_sup_o, rx_type_o, rx_cmd_o, rx_pf_o} = {!u, i, !i, t, c, p};
    {rx_nr_o, rx_sabme_o} = {n, u};
    @(posedge clk_i);
    #1;
    // Released fields turn over rather than keep a stale copy
    {rx_valid_o, rx_is_i_o, rx_is_sup_o, rx_type_o, rx_cmd_o, rx_pf_o} = {1'b0, !i, i, ~t, !c, !p};
    {rx_nr_o, rx_sabme_o} = {~n, 1'b0};
  endtask : send
  always begin
    @(posedge clk_i);
    #2;
    if (ans_dly > 0 && (sup_req_i & sup_cmd_i & sup_pf_i) === 1'b1) begin
      repeat (ans_dly) @(posedge clk_i);
      send(1'b0, ans_type, 1'b0, 1'b1, ans_nr, 1'b0);
    end
  end
endmodule : lbtr_peer

// ### verification/tb_top.sv
// Self-checking bench for the busy and timer recovery control block.
// Assumes a short T200 so each recovery round takes tens of cycles.
`timescale 1ns/100ps
module tb_top
  import lbtr_pkg::*;
;
  logic clk_i = 0, resetn_i = 0, mode_setting_i = 0, est_req_i = 0, frame_reject_i = 0;
  logic own_busy_i = 0, seq_err_i = 0, rej_sent_i = 0, i_sent_i = 0, i_pending_i = 1;
  logic reest_opt_i = 0, rx_frmr_i = 0, rx_dm_i = 0, rx_ua_i = 0, rx_valid_i, rx_is_i_i;
  logic rx_is_sup_i, rx_cmd_i, rx_pf_i, rx_sabme_i, sup_req_o, sup_cmd_o, sup_pf_o, i_allow_o;
  logic i_discard_o, peer_busy_o, recovery_o, reest_o, mdl_error_o;
  logic [1:0] rx_sup_type_i, sup_type_o;
  logic [CNT_W-1:0] retry_cnt_o;
  lbtr_seq_t vr_i = 7'h05, rx_nr_i, sup_nr_o, vs_o, va_o;
  int n_errors = 0, total_checks = 0;
  logic [1:0] cfg [3] = '{2'h0, 2'h2, 2'h3};
  logic [1:0] typ [3] = '{ST_RR, ST_REJ, ST_RR};

  lbtr_ctrl #(.T200_CYCLES(60)) u_dut (.*);
  lbtr_peer u_peer (.clk_i(clk_i), .sup_req_i(sup_req_o), .sup_cmd_i(sup_cmd_o),
    .sup_pf_i(sup_pf_o), .rx_valid_o(rx_valid_i), .rx_is_i_o(rx_is_i_i), .rx_is_sup_o(rx_is_sup_i),
    .rx_type_o(rx_sup_type_i), .rx_cmd_o(rx_cmd_i), .rx_pf_o(rx_pf_i), .rx_nr_o(rx_nr_i),
    .rx_sabme_o(rx_sabme_i));

  always #50 clk_i = ~clk_i;

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic sf(input logic i, input logic [1:0] t, input logic c, p, input lbtr_seq_t n);
    u_peer.send(i, t, c, p, n, 1'b0);
  endtask : sf
  task automatic wait_ev(input int w);
    for (int k = 0; k < 80; k++) begin
      @(posedge clk_i);
      #1;
      if (w == 0 && (sup_req_o & sup_cmd_o & sup_pf_o) === 1'b1) return;
      if ((w == 1 && reest_o === 1'b1) || (w == 2 && recovery_o === 1'b0)) return;
      if (w == 3 && sup_req_o === 1'b1) return;
    end
    check("wait", 8'h0, 8'h1);
  endtask : wait_ev
  task automatic print_verdict;
    if (n_errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (5) @(posedge clk_i);
    #1 resetn_i = 1'b1;
    check("reset", {peer_busy_o, recovery_o, retry_cnt_o}, 8'h0);
    mode_setting_i = 1'b1;
    sf(1'b0, ST_RNR, 1'b0, 1'b0, 7'h00);
    check("mode setting busy", peer_busy_o, 1'b0);
    mode_setting_i = 1'b0;
    repeat (3) begin
      @(posedge clk_i);
      #1 i_sent_i = 1'b1;
      @(posedge clk_i);
      #1 i_sent_i = 1'b0;
    end
    sf(1'b0, ST_RNR, 1'b1, 1'b1, 7'h02);
    check("busy", peer_busy_o, 1'b1);
    check("poll reply", {sup_req_o, sup_type_o, sup_cmd_o, sup_pf_o}, {1'b1, ST_RR, 2'b01});
    check("va", va_o, 7'h02);
    check("vs", vs_o, 7'h03);
    check("allow", i_allow_o, 1'b0);
    for (int k = 0; k < 3; k++) begin
      {seq_err_i, rej_sent_i} = cfg[k];
      sf(1'b0, ST_RR, 1'b1, 1'b1, 7'h02);
      check("sup type", sup_type_o, typ[k]);
    end
    {seq_err_i, rej_sent_i} = 2'h0;
    own_busy_i = 1'b1;
    wait_ev(3);
    check("busy rnr", {sup_type_o, sup_cmd_o, sup_pf_o}, {ST_RNR, 2'b00});
    sf(1'b1, ST_RR, 1'b1, 1'b1, 7'h02);
    check("discard", {i_discard_o, sup_req_o, sup_type_o, sup_pf_o}, {2'b11, ST_RNR, 1'b1});
    sf(1'b1, ST_RR, 1'b0, 1'b0, 7'h40);
    check("discard oow", {i_discard_o, va_o}, {1'b1, 7'h02});
    own_busy_i = 1'b0;
    wait_ev(3);
    check("busy end", {sup_type_o, sup_nr_o}, {ST_RR, 7'h05});
    wait_ev(0);
    check("enquiry", {recovery_o, retry_cnt_o, sup_type_o}, {1'b1, 4'h0, ST_RR});
    sf(1'b0, ST_RNR, 1'b0, 1'b0, 7'h02);
    check("busy kept", peer_busy_o, 1'b1);
    sf(1'b0, ST_RR, 1'b1, 1'b0, 7'h02);
    check("busy cleared", {peer_busy_o, i_allow_o, recovery_o}, 3'b001);
    u_peer.ans_type = ST_RNR;
    u_peer.ans_nr = 7'h02;
    u_peer.ans_dly = 4;
    wait_ev(2);
    u_peer.ans_dly = 0;
    check("final rnr", {vs_o, peer_busy_o}, {7'h02, 1'b1});
    for (int r = 0; r < 3; r++) begin
      wait_ev(0);
      check("retry", retry_cnt_o, r[3:0]);
    end
    wait_ev(1);
    check("give up", {mdl_error_o, recovery_o}, 2'b10);
    sf(1'b0, ST_RNR, 1'b0, 1'b0, va_o);
    u_peer.send(1'b0, ST_RR, 1'b0, 1'b0, 7'h00, 1'b1);
    check("sabme", peer_busy_o, 1'b0);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_i);
      #1 {est_req_i, frame_reject_i} = (k == 0) ? 2'b10 : 2'b01;
      @(posedge clk_i);
      #1 {est_req_i, frame_reject_i} = 2'b00;
      check("reest", reest_o, 1'b1);
    end
    print_verdict();
  end

  initial begin
    #200000;
    n_errors++;
    print_verdict();
  end
endmodule : tb_top
